//--- core/scm_pkg.sv
// Package for the sensor reference clock and mode select block.
// Assumes a 25 MHz reference clock; every file but scm_i2c_host imports it whole.
package scm_pkg;

   // Control-bus register offsets.
   localparam logic [7:0] REG_MODE_SEL     = 8'h03;
   localparam logic [7:0] REG_OSC_CFG      = 8'h05;
   localparam logic [7:0] REG_RATIO_FIRST  = 8'h06;
   localparam logic [7:0] REG_RATIO_SECOND = 8'h07;

   // Field positions.
   localparam int MODE_MSB       = 2;  // Mode field is [2:0] of the mode register.
   localparam int MODE_OVR_BIT   = 4;  // Override enable in the mode register.
   localparam int OSC_SEL_BIT    = 3;  // Full-rate oscillator select.
   localparam int HSDIV_SEL_MSB  = 7;  // Divider select is [7:6] of the first ratio register.
   localparam int HSDIV_SEL_LSB  = 6;
   localparam int MULT_MSB       = 4;  // Multiplier is [4:0] of the first ratio register.

   // Operating mode codes.
   localparam logic [2:0] MODE_SYNC     = 3'h0;
   localparam logic [2:0] MODE_EXT_REF  = 3'h2;
   localparam logic [2:0] MODE_AON_OSC  = 3'h3;
   localparam logic [2:0] MODE_PARALLEL = 3'h5;

   // Divider select codes and the divider values they pick.
   localparam logic [1:0] HSDIV_SEL_4  = 2'h0;
   localparam logic [1:0] HSDIV_SEL_8  = 2'h1;
   localparam logic [1:0] HSDIV_SEL_16 = 2'h2;
   localparam logic [4:0] HSDIV_4      = 5'h04;
   localparam logic [4:0] HSDIV_8      = 5'h08;
   localparam logic [4:0] HSDIV_16     = 5'h10;

   // Reset values.
   localparam logic [7:0] RATIO_FIRST_RST  = 8'h01;  // Divider 4, multiplier 1.
   localparam logic [7:0] RATIO_SECOND_RST = 8'h01;  // Denominator 1.

   // Strap settling time before sampling.
   localparam int CLK_PERIOD_NS    = 40;
   localparam int STRAP_SETTLE_NS  = 1000;
   localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Control-bus state machine.
   typedef enum logic [6:0] {
      ST_IDLE      = 7'h01,
      ST_ADDR      = 7'h02,
      ST_ADDR_ACK  = 7'h04,
      ST_WRITE     = 7'h08,
      ST_WRITE_ACK = 7'h10,
      ST_READ      = 7'h20,
      ST_READ_ACK  = 7'h40
   } scm_state_type;

endpackage

//--- core/scm_frac_clkgen.sv
// Fractional digital clock generator for the sensor reference clock.
// Assumes i_fc_tick is a same-domain pulse, one per forward-channel unit.
`timescale 1ns/1ns
`default_nettype none
module scm_frac_clkgen
   import scm_pkg::*;
(
   input  wire logic       i_ref_clk,  // Block clock.
   input  wire logic       i_srst,     // Synchronous reset, active high.
   input  wire logic       i_en,       // Run the generator.
   input  wire logic       i_fc_tick,  // One pulse per forward-channel unit.
   input  wire logic [4:0] i_hsdiv,    // High-speed divider value.
   input  wire logic [4:0] i_mult,     // Multiplier.
   input  wire logic [7:0] i_denom,    // Denominator.
   output logic            o_clk       // Generated clock, registered.
);

   logic [12:0]       acc;      // Phase accumulator, 2*M added per unit.
   wire  logic [12:0] span;     // HSDIV*N, the accumulator size of one half-period.
   wire  logic [13:0] acc_sum;  // Accumulator plus the doubled multiplier.
   wire  logic        wrap;     // A half-period boundary falls in this step.

   // Folding the divider into the threshold lets the output reach FC/HSDIV.
   assign span    = {8'h00, i_hsdiv} * {5'h00, i_denom};
   assign acc_sum = {1'b0, acc} + {8'h00, i_mult, 1'b0};
   assign wrap    = (span != 13'h0000) && (acc_sum >= {1'b0, span});

   // Add 2*M each unit and toggle whenever HSDIV*N is passed, so the output
   // frequency comes out at FC*M/(HSDIV*N).
   // Edges snap to units: an integer N/M ratio has no jitter, a fractional
   // one at most a unit, inside one divider period.
   // Only one toggle is taken per unit, so 2*M above HSDIV*N saturates.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !i_en) begin
         acc   <= 13'h0000;
         o_clk <= 1'b0;
      end else if (i_fc_tick) begin
         if (wrap) begin
            acc   <= acc_sum[12:0] - span;
            o_clk <= ~o_clk;
         end else begin
            acc <= acc_sum[12:0];
         end
      end
   end

endmodule
`default_nettype wire

//--- core/scm_top.sv
// Sensor reference clock output, mode straps and control-bus registers.
// Assumes open-drain bus wiring outside; straps arrive as digitised levels.
`timescale 1ns/1ns
`default_nettype none
module scm_top
   import scm_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR_LOW  = 7'h18,  // Address for a low strap ratio.
   parameter logic [6:0] BUS_ADDR_HIGH = 7'h19   // Address for a high strap ratio.
)(
   input  wire logic       i_ref_clk,         // 25 MHz block clock.
   input  wire logic       i_srst,            // Synchronous reset, active high.
   input  wire logic       i_scl,             // Control-bus clock pin.
   input  wire logic       i_sda,             // Control-bus data pin level.
   output logic            o_sda,             // Data pin drive level, always low.
   output logic            o_sda_oe,          // High while pulling the data pin low.
   input  wire logic [2:0] i_mode_strap,      // Digitised mode strap code.
   input  wire logic       i_addr_strap,      // Digitised address strap ratio.
   input  wire logic       i_fc_tick,         // Forward-channel unit pulse, same domain.
   output logic            o_address_strap_pin,     // Reference clock on the shared pin.
   output logic            o_address_strap_pin_oe,  // High while the pin is driven.
   output logic [2:0]      o_mode,            // Active operating mode.
   output logic            o_oscillator_rate_select, // Full-rate oscillator select.
   output logic            o_raw12_low_freq_format_ok, // Low-frequency raw12 allowed.
   output logic            o_config_done      // Strap sampling finished.
);

   // Synchronisers for pins; only the second stage is read by logic.
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] addr_sync;
   logic [2:0] mode_sync0;
   logic [2:0] mode_sync1;
   logic       scl_q;              // Previous synchronised clock for edges.
   logic       sda_q;              // Previous synchronised data for start and stop.

   // Configuration state.
   logic [4:0] settle_cnt;         // Strap settling counter.
   logic       addr_sel;           // Captured address strap.
   logic [2:0] mode;               // Operating mode field.
   logic       mode_ovr;           // Mode override enable.
   logic       osc_sel;            // Full-rate oscillator select.
   logic [7:0] ratio_first;        // Divider select and multiplier.
   logic [7:0] ratio_second;       // Denominator.

   // Bus engine state.
   scm_state_type state;           // Bus state.
   logic [2:0] bit_cnt;            // Bit within the byte.
   logic [7:0] shreg;              // Byte shifter.
   logic [7:0] ptr;                // Register pointer.
   logic       ptr_loaded;         // Pointer byte already received.
   logic       rw;                 // Read when high.
   logic       ack_on;             // Acknowledge clock phase in progress.
   wire  logic gen_clk;            // Generated reference clock.

   // Decoded events and data.
   wire logic       scl_s      = scl_sync[1];
   wire logic       sda_s      = sda_sync[1];
   wire logic       scl_rise   = scl_s && !scl_q;
   wire logic       scl_fall   = !scl_s && scl_q;
   wire logic       bus_start  = scl_s && scl_q && sda_q && !sda_s;
   wire logic       bus_stop   = scl_s && scl_q && !sda_q && sda_s;
   wire logic [7:0] rx_byte    = {shreg[6:0], sda_s};
   wire logic       last_bit   = (bit_cnt == 3'h7);
   wire logic [6:0] my_addr    = addr_sel ? BUS_ADDR_HIGH : BUS_ADDR_LOW;
   wire logic       settle_end = (settle_cnt == 5'(STRAP_SETTLE_CYC - 1));
   wire logic       wr_strobe  = (state == ST_WRITE) && scl_rise && last_bit && ptr_loaded;
   wire logic [7:0] mode_rd    = {3'h0, mode_ovr, 1'b0, mode};
   wire logic [7:0] osc_rd     = {4'h0, osc_sel, 3'h0};

   // Read data for the pointer; unmapped offsets read as zero.
   wire logic [7:0] rd_data =
      (ptr == REG_MODE_SEL)     ? mode_rd :
      (ptr == REG_OSC_CFG)      ? osc_rd :
      (ptr == REG_RATIO_FIRST)  ? ratio_first :
      (ptr == REG_RATIO_SECOND) ? ratio_second : 8'h00;

   // Divider decode; unused select code falls back to the default of 4.
   wire logic [1:0] hsdiv_sel = ratio_first[HSDIV_SEL_MSB:HSDIV_SEL_LSB];
   wire logic [4:0] hsdiv =
      (hsdiv_sel == HSDIV_SEL_8)  ? HSDIV_8 :
      (hsdiv_sel == HSDIV_SEL_16) ? HSDIV_16 : HSDIV_4;

   // Clock runs only in synchronous and external-reference modes.
   wire logic clk_out_mode = (mode == MODE_SYNC) || (mode == MODE_EXT_REF);

   // Pin synchronisers, two flops each before any logic reads them.
   always_ff @(posedge i_ref_clk) begin
      scl_sync   <= {scl_sync[0], i_scl};
      sda_sync   <= {sda_sync[0], i_sda};
      addr_sync  <= {addr_sync[0], i_addr_strap};
      mode_sync0 <= i_mode_strap;
      mode_sync1 <= mode_sync0;
      scl_q      <= scl_sync[1];
      sda_q      <= sda_sync[1];
   end

   // Straps settle after reset release, then are caught once; the shared
   // pin stays undriven until then so the address strap can be read.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         settle_cnt    <= 5'h00;
         o_config_done <= 1'b0;
         addr_sel      <= 1'b0;
      end else if (!o_config_done) begin
         settle_cnt <= settle_cnt + 5'h01;
         if (settle_end) begin
            o_config_done <= 1'b1;
            addr_sel      <= addr_sync[1];
         end
      end
   end

   // Register file. Strap mode loads once; the host changes the mode field
   // only while the override bit is already set.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         mode         <= MODE_SYNC;
         mode_ovr     <= 1'b0;
         osc_sel      <= 1'b0;
         ratio_first  <= RATIO_FIRST_RST;
         ratio_second <= RATIO_SECOND_RST;
      end else if (!o_config_done) begin
         if (settle_end) begin
            mode <= mode_sync1;
         end
      end else if (wr_strobe) begin
         if (ptr == REG_MODE_SEL) begin
            mode_ovr <= rx_byte[MODE_OVR_BIT];
            if (mode_ovr) begin
               mode <= rx_byte[MODE_MSB:0];
            end
         end else if (ptr == REG_OSC_CFG) begin
            osc_sel <= rx_byte[OSC_SEL_BIT];
         end else if (ptr == REG_RATIO_FIRST) begin
            ratio_first <= rx_byte;
         end else if (ptr == REG_RATIO_SECOND) begin
            ratio_second <= rx_byte;
         end
      end
   end

   // Control-bus slave: address match, pointer byte, then data bytes with
   // auto-increment. Data changes on falling clock, is sampled on rising.
   // Silent until straps are caught, since the address is unknown.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !o_config_done) begin
         state      <= ST_IDLE;
         bit_cnt    <= 3'h0;
         shreg      <= 8'h00;
         ptr        <= 8'h00;
         ptr_loaded <= 1'b0;
         rw         <= 1'b0;
         ack_on     <= 1'b0;
         o_sda_oe   <= 1'b0;
      end else if (bus_start) begin
         state      <= ST_ADDR;
         bit_cnt    <= 3'h0;
         ptr_loaded <= 1'b0;
         ack_on     <= 1'b0;
         o_sda_oe   <= 1'b0;
      end else if (bus_stop) begin
         state    <= ST_IDLE;
         ack_on   <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         case (state)
            ST_ADDR: begin
               if (scl_rise) begin
                  shreg   <= rx_byte;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (last_bit) begin
                     // Foreign addresses are left alone on a shared bus.
                     state <= (rx_byte[7:1] == my_addr) ? ST_ADDR_ACK : ST_IDLE;
                     rw    <= rx_byte[0];
                  end
               end
            end
            ST_ADDR_ACK, ST_WRITE_ACK: begin
               if (scl_fall && !ack_on) begin
                  ack_on   <= 1'b1;
                  o_sda_oe <= 1'b1;
               end else if (scl_fall) begin
                  ack_on <= 1'b0;
                  if (state == ST_ADDR_ACK && rw) begin
                     shreg    <= rd_data;
                     o_sda_oe <= ~rd_data[7];
                     state    <= ST_READ;
                  end else begin
                     o_sda_oe <= 1'b0;
                     state    <= ST_WRITE;
                  end
               end
            end
            ST_WRITE: begin
               if (scl_rise) begin
                  shreg   <= rx_byte;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (last_bit) begin
                     state <= ST_WRITE_ACK;
                     if (!ptr_loaded) begin
                        ptr        <= rx_byte;
                        ptr_loaded <= 1'b1;
                     end else begin
                        ptr <= ptr + 8'h01;
                     end
                  end
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (last_bit) begin
                     o_sda_oe <= 1'b0;
                     ptr      <= ptr + 8'h01;
                     state    <= ST_READ_ACK;
                  end else begin
                     shreg    <= {shreg[6:0], 1'b0};
                     o_sda_oe <= ~shreg[6];
                  end
               end
            end
            ST_READ_ACK: begin
               // A high level at the ack clock ends the read.
               if (scl_rise) begin
                  if (sda_s) begin
                     state <= ST_IDLE;
                  end else begin
                     ack_on <= 1'b1;
                  end
               end else if (scl_fall && ack_on) begin
                  ack_on   <= 1'b0;
                  shreg    <= rd_data;
                  o_sda_oe <= ~rd_data[7];
                  state    <= ST_READ;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Fractional generator for the reference clock.
   scm_frac_clkgen u_clkgen (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_en      (o_config_done && clk_out_mode),
      .i_fc_tick (i_fc_tick),
      .i_hsdiv   (hsdiv),
      .i_mult    (ratio_first[MULT_MSB:0]),
      .i_denom   (ratio_second),
      .o_clk     (gen_clk)
   );

   // Output flops. The shared pin turns into the clock output only after
   // straps are caught, and only in modes that provide it.
   // Parallel mode has no low-frequency raw12 format.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_address_strap_pin        <= 1'b0;
         o_address_strap_pin_oe     <= 1'b0;
         o_mode                     <= MODE_SYNC;
         o_oscillator_rate_select   <= 1'b0;
         o_raw12_low_freq_format_ok <= 1'b0;
         o_sda                      <= 1'b0;
      end else begin
         o_address_strap_pin        <= gen_clk && o_config_done && clk_out_mode;
         o_address_strap_pin_oe     <= o_config_done && clk_out_mode;
         o_mode                     <= mode;
         o_oscillator_rate_select   <= osc_sel;
         o_raw12_low_freq_format_ok <= o_config_done && (mode != MODE_PARALLEL);
         o_sda                      <= 1'b0;
      end
   end

endmodule
`default_nettype wire

//--- dv/scm_top_assertions.sv
// Concurrent checks on the ports of scm_top, attached by bind at the foot.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module scm_top_assertions
   import scm_pkg::*;
(
   input wire logic       i_ref_clk,                  // Block clock.
   input wire logic       i_srst,                     // Synchronous reset.
   input wire logic       i_scl,                      // Bus clock pin.
   input wire logic       i_sda,                      // Bus data pin.
   input wire logic       o_sda,                      // Data drive level.
   input wire logic       o_sda_oe,                   // Data pull-low enable.
   input wire logic [2:0] i_mode_strap,               // Mode strap code.
   input wire logic       i_addr_strap,               // Address strap.
   input wire logic       i_fc_tick,                  // Forward-channel pulse.
   input wire logic       o_address_strap_pin,        // Shared clock pin.
   input wire logic       o_address_strap_pin_oe,     // Shared pin enable.
   input wire logic [2:0] o_mode,                     // Active mode.
   input wire logic       o_oscillator_rate_select,   // Full-rate select.
   input wire logic       o_raw12_low_freq_format_ok, // Raw12 low-freq allowed.
   input wire logic       o_config_done               // Strap sampling done.
);
   logic [7:0] rel_cnt;  // Cycles since reset release, saturating.
   wire logic  clk_mode = (o_mode == MODE_SYNC) || (o_mode == MODE_EXT_REF);  // Clock modes.
   // Counting from release lets the sampling moment be pinned exactly.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rel_cnt <= 8'h00;
      end else if (rel_cnt != 8'hff) begin
         rel_cnt <= rel_cnt + 8'h01;
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   cfg_time_a: assert property ($rose(o_config_done) |-> rel_cnt == STRAP_SETTLE_CYC)
      else $error("Strap sampling finished at the wrong cycle.");
   cfg_hold_a: assert property (o_config_done |=> o_config_done)
      else $error("Configuration done dropped without reset.");
   pin_after_cfg_a: assert property (o_address_strap_pin_oe |-> o_config_done)
      else $error("Shared pin driven before strap sampling.");
   mode_strap_a: assert property ($rose(o_config_done) |-> ##[0:2] o_mode == i_mode_strap)
      else $error("Mode does not follow the strap.");
   clk_on_a: assert property ((o_config_done && clk_mode) [*3] |-> o_address_strap_pin_oe)
      else $error("Clock pin not driven in a clock mode.");
   aon_off_a: assert property ((o_mode == MODE_AON_OSC) [*3] |-> !o_address_strap_pin_oe)
      else $error("Clock pin driven in internal oscillator mode.");
   raw12_off_a: assert property ((o_mode == MODE_PARALLEL) [*3] |-> !o_raw12_low_freq_format_ok)
      else $error("Raw12 low-freq allowed in parallel mode.");
   raw12_on_a: assert property ((o_config_done && o_mode != MODE_PARALLEL) [*3]
                               |-> o_raw12_low_freq_format_ok)
      else $error("Raw12 low-freq refused outside parallel mode.");
   bus_quiet_a: assert property (!o_config_done |-> !o_sda_oe)
      else $error("Bus answered before configuration.");
   ack_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*4])
      else $error("Data pull-low too short.");
   sda_low_a: assert property (o_sda == 1'b0)
      else $error("Data pin drive level not low.");
   cover property ($rose(o_config_done));
   cover property (o_mode == MODE_PARALLEL);
   cover property ($rose(o_sda_oe));
endmodule
bind scm_top scm_top_assertions u_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
   .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .i_mode_strap(i_mode_strap), .i_addr_strap(i_addr_strap), .i_fc_tick(i_fc_tick),
   .o_address_strap_pin(o_address_strap_pin), .o_address_strap_pin_oe(o_address_strap_pin_oe),
   .o_mode(o_mode), .o_oscillator_rate_select(o_oscillator_rate_select),
   .o_raw12_low_freq_format_ok(o_raw12_low_freq_format_ok), .o_config_done(o_config_done));
`default_nettype wire

//--- dv/scm_i2c_host.sv
// Behavioural control-bus host that writes and reads registers of the block.
// Assumes a pull-up on the data line, resolved by the bench from all enables.
`timescale 1ns/1ns
`default_nettype none
module scm_i2c_host (
   input  wire logic i_ref_clk,  // Paces every bus phase.
   input  wire logic i_sda,      // Resolved data line.
   output var logic  o_scl,      // Bus clock, high when idle.
   output var logic  o_sda_oe    // High while pulling data low.
);
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // Six cycles a phase keeps each phase longer than the synchroniser lag.
   task automatic hp();
      repeat (6) @(negedge i_ref_clk);
   endtask
   // Data moves only a full phase after the clock falls, so no false start or stop.
   task automatic bit_x(input logic b, output logic r);
      o_sda_oe = ~b;
      hp();
      o_scl = 1'b1;
      hp();
      r = i_sda;
      o_scl = 1'b0;
      hp();
   endtask
   // Start and repeated start: data falls while the clock is high.
   task automatic start();
      o_sda_oe = 1'b0;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_oe = 1'b1;
      hp();
      o_scl = 1'b0;
      hp();
   endtask
   // Stop: data rises while the clock is high, then the line is left released.
   task automatic stop();
      o_sda_oe = 1'b1;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_oe = 1'b0;
      hp();
   endtask
   // Byte out, most significant bit first, then the device's acknowledge.
   task automatic tx(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   // Byte in; a high acknowledge bit ends the read.
   task automatic rx(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(last, r);
   endtask
   // Register write: address, pointer, data, each acknowledged.
   task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic ack);
      logic k1, k2, k3;
      start();
      tx({a, 1'b0}, k1);
      tx(p, k2);
      tx(d, k3);
      stop();
      ack = k1 & k2 & k3;
   endtask
   // Register read: pointer write, repeated start, one byte back.
   task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
      logic k;
      start();
      tx({a, 1'b0}, k);
      tx(p, k);
      start();
      tx({a, 1'b1}, k);
      rx(1'b1, d);
      stop();
   endtask
endmodule
`default_nettype wire

//--- dv/scm_top_tb.sv
// Self-checking bench for scm_top with a bus host model on the data pins.
// Assumes the design defaults for both bus addresses; inputs change on falling edges.
`timescale 1ns/1ns
`default_nettype none
module scm_top_tb
   import scm_pkg::*;
   ;
   logic       i_ref_clk, i_srst, i_fc_tick, addr_strap, scl, h_oe, ack;  // Bench drives.
   logic [2:0] mode_strap;                                               // Mode strap.
   logic [7:0] rdat;                                                     // Read data.
   logic       sda_drv, sda_oe, pin, pin_oe, osc_sel, raw_ok, cfg_done;  // Design outputs.
   logic [2:0] mode;                                                     // Active mode.
   wire logic  sda = ~(sda_oe | h_oe);  // Pull-up wins unless someone pulls low.
   int         error_cnt, checks;       // Verdict counters.
   scm_top DUT (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda),
      .o_sda(sda_drv), .o_sda_oe(sda_oe), .i_mode_strap(mode_strap), .i_addr_strap(addr_strap),
      .i_fc_tick(i_fc_tick), .o_address_strap_pin(pin), .o_address_strap_pin_oe(pin_oe),
      .o_mode(mode), .o_oscillator_rate_select(osc_sel), .o_raw12_low_freq_format_ok(raw_ok),
      .o_config_done(cfg_done));
   scm_i2c_host u_host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   // Forward-channel pulse every second cycle, so the unit rate is half the clock.
   always @(negedge i_ref_clk) i_fc_tick <= (i_fc_tick !== 1'b1);
   task automatic summarize();
      $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Reset, then wait a bounded time for strap sampling to finish.
   task automatic do_reset(input logic [2:0] m, input logic a);
      int t;
      @(negedge i_ref_clk);
      mode_strap = m;
      addr_strap = a;
      i_srst = 1'b1;
      repeat (20) @(negedge i_ref_clk);
      i_srst = 1'b0;
      @(negedge i_ref_clk);
      chk(8'(pin_oe), 8'h00);
      t = 0;
      while (cfg_done !== 1'b1 && t < 100) begin
         @(negedge i_ref_clk);
         t++;
      end
      if (t >= 100) begin
         error_cnt++;
         summarize();
      end
      repeat (3) @(negedge i_ref_clk);
   endtask
   task automatic exp_mode(input logic [2:0] m);
      chk(8'(mode), 8'(m));
      chk(8'(pin_oe), 8'(m == MODE_SYNC || m == MODE_EXT_REF));
      chk(8'(raw_ok), 8'(m != MODE_PARALLEL));
   endtask
   // Rising edges on the pin over a window, within one edge of the expectation.
   task automatic freq_chk(input int w, e);
      int   n;
      logic prev;
      n = 0;
      prev = pin;
      repeat (w) begin
         @(negedge i_ref_clk);
         if (pin && !prev) n++;
         prev = pin;
      end
      chk(8'(n + 1 >= e && n <= e + 1), 8'h01);
   endtask
   task automatic t_straps();
      do_reset(MODE_EXT_REF, 1'b1);
      exp_mode(MODE_EXT_REF);
      u_host.rd(DUT.BUS_ADDR_HIGH, REG_RATIO_FIRST, rdat);
      chk(rdat, RATIO_FIRST_RST);
      u_host.rd(DUT.BUS_ADDR_HIGH, REG_RATIO_SECOND, rdat);
      chk(rdat, RATIO_SECOND_RST);
      freq_chk(800, 100);
      $display("test straps done");
   endtask
   // Divider choices keep the unit rate over the divider far below the limit.
   task automatic ratio_case(input logic [1:0] s, input logic [4:0] m, input logic [7:0] n,
                             input int e);
      u_host.wr(DUT.BUS_ADDR_HIGH, REG_RATIO_FIRST, {s, 1'b0, m}, ack);
      u_host.wr(DUT.BUS_ADDR_HIGH, REG_RATIO_SECOND, n, ack);
      u_host.rd(DUT.BUS_ADDR_HIGH, REG_RATIO_FIRST, rdat);
      chk(rdat, {s, 1'b0, m});
      u_host.rd(DUT.BUS_ADDR_HIGH, REG_RATIO_SECOND, rdat);
      chk(rdat, n);
      freq_chk(800, e);
   endtask
   task automatic t_ratio();
      ratio_case(HSDIV_SEL_8, 5'h02, 8'h02, 50);
      ratio_case(HSDIV_SEL_16, 5'h04, 8'h01, 100);
      $display("test ratio done");
   endtask
   task automatic t_mode();
      logic [2:0] codes [4] = '{MODE_SYNC, MODE_EXT_REF, MODE_AON_OSC, MODE_PARALLEL};
      u_host.wr(DUT.BUS_ADDR_HIGH, REG_MODE_SEL, 8'h03, ack);
      repeat (4) @(negedge i_ref_clk);
      exp_mode(MODE_EXT_REF);
      u_host.wr(DUT.BUS_ADDR_HIGH, REG_MODE_SEL, 8'h10, ack);
      foreach (codes[i]) begin
         u_host.wr(DUT.BUS_ADDR_HIGH, REG_MODE_SEL, {5'h02, codes[i]}, ack);
         repeat (4) @(negedge i_ref_clk);
         exp_mode(codes[i]);
         u_host.rd(DUT.BUS_ADDR_HIGH, REG_MODE_SEL, rdat);
         chk(rdat, {5'h02, codes[i]});
      end
      $display("test mode done");
   endtask
   task automatic t_misc();
      u_host.wr(DUT.BUS_ADDR_HIGH, REG_OSC_CFG, 8'h08, ack);
      chk(8'(ack), 8'h01);
      repeat (4) @(negedge i_ref_clk);
      chk(8'(osc_sel), 8'h01);
      u_host.rd(DUT.BUS_ADDR_HIGH, 8'h20, rdat);
      chk(rdat, 8'h00);
      u_host.wr(DUT.BUS_ADDR_LOW, REG_OSC_CFG, 8'h00, ack);
      chk(8'(ack), 8'h00);
      chk(8'(osc_sel), 8'h01);
      $display("test misc done");
   endtask
   task automatic t_reset2();
      do_reset(MODE_SYNC, 1'b0);
      exp_mode(MODE_SYNC);
      chk(8'(osc_sel), 8'h00);
      u_host.wr(DUT.BUS_ADDR_LOW, REG_OSC_CFG, 8'h08, ack);
      chk(8'(ack), 8'h01);
      u_host.wr(DUT.BUS_ADDR_HIGH, REG_OSC_CFG, 8'h00, ack);
      chk(8'(ack), 8'h00);
      chk(8'(osc_sel), 8'h01);
      $display("test second reset done");
   endtask
   initial begin
      i_srst = 1'b1;
      mode_strap = MODE_EXT_REF;
      addr_strap = 1'b1;
      error_cnt = 0;
      checks = 0;
      t_straps();
      t_ratio();
      t_mode();
      t_misc();
      t_reset2();
      summarize();
   end
endmodule
`default_nettype wire
